/* common/pst_map.svh */
/*
  constants of the programmable stage timer: widths, select base, reset
  values. assumes inclusion by bare name from the package and the modules.
*/
`ifndef PST_MAP_SVH
`define PST_MAP_SVH

`define PST_STAGES 24
`define PST_SEC_W 8
`define PST_NSEC 3
`define PST_SEL_W 4
`define PST_IDX_W 5
`define PST_SEL_BASE 5'h08
`define PST_MONO_W 8
`define PST_CNT_RST 24'h000000
`define PST_OSC_B_RST 1'b1

`endif

/* common/pst_pkg.sv */
/*
  types of the programmable stage timer: mode enum, control carrier and
  the state structs of each module. assumes pst_map.svh on the path.
*/
`include "pst_map.svh"

package pst_pkg;

  typedef enum logic [1:0] {
    PST_RUN = 2'b00,
    PST_SET = 2'b01,
    PST_TEST = 2'b10
  } pst_mode_e;

  typedef struct packed {
    logic set_lvl;
    logic reset_lvl;
    logic skip8;
    logic count_hold;
    logic osc_stop;
  } pst_ctrl_s;

  typedef struct packed {
    pst_mode_e mode;
    logic latch;
    logic [`PST_STAGES-1:0] cnt;
    logic dec;
    logic osc_a;
    logic osc_b;
    logic test;
  } pst_state_s;

  typedef struct packed {
    logic prev;
  } pst_fall_s;

  typedef struct packed {
    logic trig_prev;
    logic busy;
    logic [`PST_MONO_W-1:0] left;
  } pst_shot_s;

endpackage : pst_pkg

/* design/pst_fall_det.sv */
/*
  falling edge detector for the count clock input.
  assumes the input is synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "pst_map.svh"

module pst_fall_det (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // level in, edge out
  input wire logic level_in,
  output logic fall
);

  pst_pkg::pst_fall_s st_ff;
  pst_pkg::pst_fall_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = level_in;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // high-to-low seen between the last sample and this one
  assign fall = st_ff.prev & ~level_in;

  property p_fall_once;
    @(posedge ref_clk) disable iff (rst)
    fall |=> !fall;
  endproperty
  a_fall_once: assert property (p_fall_once)
    else $error("falling edge flagged two cycles running");

endmodule : pst_fall_det

/* design/pst_one_shot.sv */
/*
  one-shot pulse stage: a rising trigger starts a pulse of width cycles.
  assumes width and enable are steady while a pulse runs.
*/
`timescale 1ns/1ps
`include "pst_map.svh"

module pst_one_shot #(
  parameter int WIDTH_W = `PST_MONO_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // configuration
  input wire logic enable,
  input wire logic [WIDTH_W-1:0] width,
  // trigger and pulse
  input wire logic trig,
  output logic pulse
);

  if (WIDTH_W != `PST_MONO_W) begin : g_bad_width
    $error("pst_one_shot: WIDTH_W must match the state field width");
  end

  pst_pkg::pst_shot_s st_ff;
  pst_pkg::pst_shot_s nxt_st;
  logic rise;

  assign rise = trig & ~st_ff.trig_prev;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.trig_prev = trig;
    if (!enable) begin
      nxt_st.busy = 1'b0;
    end else if (st_ff.busy) begin
      if (st_ff.left == '0) begin
        nxt_st.busy = 1'b0;
      end else begin
        nxt_st.left = st_ff.left - 1'b1;
      end
    end else if (rise && width != '0) begin
      nxt_st.busy = 1'b1;
      nxt_st.left = width - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pulse = st_ff.busy;

  property p_shot_start;
    @(posedge ref_clk) disable iff (rst)
    (enable && rise && !st_ff.busy && width != '0)
      |=> pulse && (st_ff.left == $past(width) - 1'b1);
  endproperty
  a_shot_start: assert property (p_shot_start)
    else $error("one-shot did not start with the configured width");

endmodule : pst_one_shot

/* design/pst_timer.sv */
/*
  programmable stage timer: 24-stage counter stepped by falling edges of
  count_clock_in, stage select onto decode_out, optional one-shot, set and
  reset handling, test mode and oscillator drive outputs.
  assumes all inputs synchronous to ref_clk (10 MHz) and that the party
  outside drops set and reset together when leaving test mode.
*/
`timescale 1ns/1ps
`include "pst_map.svh"

module pst_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // count clock from external source or oscillator loop
  input wire logic count_clock_in,
  // control levels
  input wire pst_pkg::pst_ctrl_s ctrl,
  // stage select, bit 3 most significant
  input wire logic [`PST_SEL_W-1:0] stage_sel,
  // one-shot configuration
  input wire logic mono_en,
  input wire logic [`PST_MONO_W-1:0] mono_width,
  // tap output
  output logic decode_out,
  // oscillator drive outputs
  output logic osc_drive_a,
  output logic osc_drive_b,
  // status
  output logic [`PST_STAGES-1:0] stage_q,
  output logic test_active
);

  if (`PST_NSEC * `PST_SEC_W != `PST_STAGES) begin : g_bad_split
    $error("pst_timer: sections must cover every stage");
  end

  pst_pkg::pst_state_s st_ff;
  pst_pkg::pst_state_s nxt_st;
  logic fall;
  logic edge_g;
  logic test_req;
  logic osc_run;
  logic shot_pulse;
  logic [`PST_IDX_W-1:0] sel_idx;
  logic sel_bit;
  logic [`PST_NSEC-1:0] cin;
  logic [`PST_STAGES-1:0] cnt_adv;

  pst_fall_det u_fall (
    .ref_clk(ref_clk),
    .rst(rst),
    .level_in(count_clock_in),
    .fall(fall)
  );

  pst_one_shot #(
    .WIDTH_W(`PST_MONO_W)
  ) u_shot (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(mono_en),
    .width(mono_width),
    .trig(sel_bit),
    .pulse(shot_pulse)
  );

  assign test_req = ctrl.skip8 & ctrl.set_lvl & ctrl.reset_lvl;

  assign osc_run = ~(ctrl.set_lvl | ctrl.reset_lvl | ctrl.osc_stop);

  // gated counting edge, no start-up delay
  assign edge_g = fall & ~ctrl.count_hold & ~ctrl.osc_stop;

  // stage index, same cell for both skip settings
  assign sel_idx = `PST_SEL_BASE + {1'b0, stage_sel};
  assign sel_bit = st_ff.cnt[sel_idx];

  // synchronous sections, carry from all-ones section below
  for (genvar gi = 0; gi < `PST_NSEC; gi++) begin : g_sec
    if (gi == 0) begin : g_first
      // first section idle when skipped, parallel in test
      assign cin[gi] = test_req ? edge_g : (edge_g & ~ctrl.skip8);
    end else if (gi == 1) begin : g_second
      // skip feeds the edge straight into stage 9
      assign cin[gi] = (test_req | ctrl.skip8) ? edge_g :
        (cin[gi-1] & (&st_ff.cnt[gi*`PST_SEC_W-1 -: `PST_SEC_W]));
    end else begin : g_rest
      // each section counts the edge alone in test mode
      assign cin[gi] = test_req ? edge_g :
        (cin[gi-1] & (&st_ff.cnt[gi*`PST_SEC_W-1 -: `PST_SEC_W]));
    end
    // advance by one per counted edge
    assign cnt_adv[gi*`PST_SEC_W +: `PST_SEC_W] =
      st_ff.cnt[gi*`PST_SEC_W +: `PST_SEC_W] +
      {{(`PST_SEC_W-1){1'b0}}, cin[gi]};
  end

  always_comb begin
    nxt_st = st_ff;
    // registered copy of the clock input and its complement, both gated by osc_run
    nxt_st.osc_a = osc_run & count_clock_in;
    nxt_st.osc_b = ~(osc_run & count_clock_in);
    nxt_st.test = test_req;
    if (test_req) begin
      nxt_st.mode = pst_pkg::PST_TEST;
      nxt_st.latch = 1'b0;
      nxt_st.cnt = cnt_adv;
    end else if (ctrl.reset_lvl) begin
      // reset clears and wins over set
      nxt_st.mode = pst_pkg::PST_RUN;
      nxt_st.latch = 1'b0;
      nxt_st.cnt = `PST_CNT_RST;
    end else if (ctrl.set_lvl) begin
      nxt_st.mode = pst_pkg::PST_SET;
      nxt_st.latch = 1'b1;
      nxt_st.cnt = `PST_CNT_RST;
    end else begin
      unique case (st_ff.mode)
        pst_pkg::PST_RUN: begin
          nxt_st.cnt = cnt_adv;
        end
        pst_pkg::PST_SET: begin
          if (edge_g) begin
            nxt_st.latch = 1'b0;
            nxt_st.mode = pst_pkg::PST_RUN;
          end
        end
        pst_pkg::PST_TEST: begin
          // set and reset fell together: series chain again
          nxt_st.mode = pst_pkg::PST_RUN;
          nxt_st.cnt = cnt_adv;
        end
        default: begin
          nxt_st.mode = pst_pkg::PST_RUN;
        end
      endcase
    end
    if (test_req) begin
      nxt_st.dec = sel_bit;
    end else if (ctrl.reset_lvl) begin
      nxt_st.dec = 1'b0;
    end else if (ctrl.set_lvl) begin
      nxt_st.dec = 1'b1;
    end else if (mono_en) begin
      nxt_st.dec = st_ff.latch | shot_pulse;
    end else begin
      // direct stage level, square wave when free running
      nxt_st.dec = st_ff.latch | sel_bit;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.mode <= pst_pkg::PST_RUN;
      st_ff.cnt <= `PST_CNT_RST;
      st_ff.osc_b <= `PST_OSC_B_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign decode_out = st_ff.dec;
  assign osc_drive_a = st_ff.osc_a;
  assign osc_drive_b = st_ff.osc_b;
  assign stage_q = st_ff.cnt;
  assign test_active = st_ff.test;

  sequence s_quiet;
    !ctrl.set_lvl && !ctrl.reset_lvl;
  endsequence

  sequence s_run_edge;
    s_quiet ##0 (st_ff.mode == pst_pkg::PST_RUN) ##0 edge_g;
  endsequence

  property p_set_high;
    @(posedge ref_clk) disable iff (rst)
    (ctrl.set_lvl && !ctrl.reset_lvl)
      |=> decode_out && stage_q == `PST_CNT_RST;
  endproperty
  a_set_high: assert property (p_set_high)
    else $error("set did not force tap high and clear stages");

  property p_first_edge;
    @(posedge ref_clk) disable iff (rst)
    (s_quiet ##0 st_ff.mode == pst_pkg::PST_SET ##0 edge_g)
      |=> !st_ff.latch;
  endproperty
  a_first_edge: assert property (p_first_edge)
    else $error("first edge after set did not clear the latch");

  property p_no_count_first;
    @(posedge ref_clk) disable iff (rst)
    (s_quiet ##0 st_ff.mode == pst_pkg::PST_SET)
      |=> stage_q == `PST_CNT_RST;
  endproperty
  a_no_count_first: assert property (p_no_count_first)
    else $error("counter moved before the second edge");

  property p_osc_set;
    @(posedge ref_clk) disable iff (rst)
    ctrl.set_lvl |=> !osc_drive_a && osc_drive_b;
  endproperty
  a_osc_set: assert property (p_osc_set)
    else $error("oscillator ran while set was high");

  property p_reset_low;
    @(posedge ref_clk) disable iff (rst)
    (ctrl.reset_lvl && !test_req)
      |=> !decode_out && stage_q == `PST_CNT_RST;
  endproperty
  a_reset_low: assert property (p_reset_low)
    else $error("reset did not force tap low and clear stages");

  property p_osc_reset;
    @(posedge ref_clk) disable iff (rst)
    ctrl.reset_lvl |=> !osc_drive_a && osc_drive_b;
  endproperty
  a_osc_reset: assert property (p_osc_reset)
    else $error("oscillator ran while reset was high");

  property p_step;
    @(posedge ref_clk) disable iff (rst)
    (s_run_edge ##0 !ctrl.skip8)
      |=> stage_q == $past(stage_q) + 24'h000001;
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not advance by one on the edge");

  property p_skip;
    @(posedge ref_clk) disable iff (rst)
    (s_run_edge ##0 ctrl.skip8)
      |=> stage_q[7:0] == $past(stage_q[7:0]) &&
          stage_q[23:8] == $past(stage_q[23:8]) + 16'h0001;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip did not bypass the first section");

  property p_hold;
    @(posedge ref_clk) disable iff (rst)
    (s_quiet ##0 ctrl.count_hold) |=> stage_q == $past(stage_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count moved under count-hold");

  property p_osc_stop;
    @(posedge ref_clk) disable iff (rst)
    (s_quiet ##0 ctrl.osc_stop)
      |=> stage_q == $past(stage_q) && !osc_drive_a;
  endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("oscillator stop did not halt counting");

  property p_direct;
    @(posedge ref_clk) disable iff (rst)
    (s_quiet ##0 !mono_en ##0 st_ff.mode == pst_pkg::PST_RUN)
      |=> decode_out == $past(sel_bit);
  endproperty
  a_direct: assert property (p_direct)
    else $error("tap did not follow the selected stage");

  property p_sel_map;
    @(posedge ref_clk) disable iff (rst)
    (s_quiet ##0 !mono_en ##0 stage_sel == 4'hF ##0
     st_ff.mode == pst_pkg::PST_RUN) |=> decode_out == $past(stage_q[23]);
  endproperty
  a_sel_map: assert property (p_sel_map)
    else $error("top code did not pick the last stage");

  property p_test;
    @(posedge ref_clk) disable iff (rst)
    (test_req && edge_g)
      |=> stage_q[7:0] == $past(stage_q[7:0]) + 8'h01 &&
          stage_q[23:16] == $past(stage_q[23:16]) + 8'h01;
  endproperty
  a_test: assert property (p_test)
    else $error("test sections did not count in parallel");

  property p_both_high;
    @(posedge ref_clk) disable iff (rst)
    (ctrl.set_lvl && ctrl.reset_lvl && !ctrl.skip8)
      |=> !decode_out && stage_q == `PST_CNT_RST;
  endproperty
  a_both_high: assert property (p_both_high)
    else $error("reset did not win over set");

  property p_osc_copy;
    @(posedge ref_clk) disable iff (rst)
    osc_run |=> osc_drive_a == $past(count_clock_in) &&
                osc_drive_b == !$past(count_clock_in);
  endproperty
  a_osc_copy: assert property (p_osc_copy)
    else $error("drive outputs are not a copy of the clock input");

endmodule : pst_timer

/* verification/programmable_stage_timer_tb.sv */
/*
  self-checking bench of the programmable stage timer: counting, holds,
  set and reset, test mode, stage select and the one-shot tap.
  assumes pst_pkg, pst_map.svh and the clock source model are compiled.
*/
`timescale 1ns/1ps
`include "pst_map.svh"

module programmable_stage_timer_tb;
  logic ref_clk;
  logic rst;
  pst_pkg::pst_ctrl_s ctrl;
  logic [3:0] stage_sel;
  logic mono_en;
  logic [7:0] mono_width;
  logic decode_out, osc_drive_a, osc_drive_b, test_active;
  logic [23:0] stage_q;
  logic go, slow, clk_in, busy;
  logic [15:0] n_edges;
  int errors;
  int compares;

  pst_timer i_dut (.ref_clk(ref_clk), .rst(rst), .count_clock_in(clk_in),
    .ctrl(ctrl), .stage_sel(stage_sel), .mono_en(mono_en),
    .mono_width(mono_width), .decode_out(decode_out),
    .osc_drive_a(osc_drive_a), .osc_drive_b(osc_drive_b),
    .stage_q(stage_q), .test_active(test_active));

  pst_clk_src i_src (.ref_clk(ref_clk), .go(go), .n_edges(n_edges),
    .slow(slow), .clk_out(clk_in), .busy(busy));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc

  task automatic launch(input int k);
    @(posedge ref_clk);
    go <= 1'b1;
    n_edges <= k[15:0];
    @(posedge ref_clk);
    go <= 1'b0;
  endtask : launch

  // bounded wait for the burst to end, then let the counter settle
  task automatic wait_idle();
    int w;
    w = 0;
    @(negedge ref_clk);
    while (busy === 1'b1) begin
      @(negedge ref_clk);
      w++;
      if (w > 1000) begin
        errors++;
        $display("[ERR] clock source exp idle got busy");
        give_verdict();
      end
    end
    cyc(4);
    @(negedge ref_clk);
  endtask : wait_idle

  task automatic pulses(input int k);
    launch(k);
    wait_idle();
  endtask : pulses

  // counts tap-high cycles over a window of win cycles that opens skip cycles after a burst is launched
  task automatic run_count(input int k, input int skip, input int win,
                           output int hi);
    launch(k);
    cyc(skip);
    hi = 0;
    repeat (win) begin
      @(negedge ref_clk);
      if (decode_out === 1'b1) hi++;
    end
    wait_idle();
  endtask : run_count

  task automatic t_count();
    pulses(5);
    chk("stage_q", 24'h000005, stage_q);
    chk("osc_drive_a run", 24'h1, {23'h0, osc_drive_a});
    chk("osc_drive_b run", 24'h0, {23'h0, osc_drive_b});
    @(posedge ref_clk);
    ctrl.count_hold <= 1'b1;
    pulses(4);
    chk("stage_q hold", 24'h000005, stage_q);
    @(posedge ref_clk);
    ctrl.count_hold <= 1'b0;
    pulses(1);
    chk("stage_q resume", 24'h000006, stage_q);
    @(posedge ref_clk);
    ctrl.osc_stop <= 1'b1;
    slow <= 1'b1;
    pulses(3);
    chk("stage_q osc stop", 24'h000006, stage_q);
    chk("osc_drive_a", 24'h0, {23'h0, osc_drive_a});
    @(posedge ref_clk);
    ctrl.osc_stop <= 1'b0;
    pulses(3);
    chk("stage_q slow", 24'h000009, stage_q);
    @(posedge ref_clk);
    slow <= 1'b0;
  endtask : t_count

  task automatic t_set();
    @(posedge ref_clk);
    ctrl.set_lvl <= 1'b1;
    cyc(2);
    @(negedge ref_clk);
    chk("decode_out set", 24'h1, {23'h0, decode_out});
    chk("stage_q set", 24'h0, stage_q);
    chk("osc_drive_b set", 24'h1, {23'h0, osc_drive_b});
    chk("osc_drive_a set", 24'h0, {23'h0, osc_drive_a});
    @(posedge ref_clk);
    ctrl.set_lvl <= 1'b0;
    pulses(1);
    chk("decode_out first", 24'h0, {23'h0, decode_out});
    chk("stage_q first", 24'h0, stage_q);
    pulses(1);
    chk("stage_q second", 24'h000001, stage_q);
  endtask : t_set

  task automatic t_reset();
    pulses(2);
    @(posedge ref_clk);
    ctrl.reset_lvl <= 1'b1;
    cyc(2);
    @(negedge ref_clk);
    chk("stage_q reset", 24'h0, stage_q);
    chk("osc_drive_b reset", 24'h1, {23'h0, osc_drive_b});
    pulses(2);
    chk("stage_q in reset", 24'h0, stage_q);
    @(posedge ref_clk);
    ctrl.set_lvl <= 1'b1;
    cyc(2);
    @(negedge ref_clk);
    chk("decode_out both", 24'h0, {23'h0, decode_out});
    @(posedge ref_clk);
    ctrl.set_lvl <= 1'b0;
    ctrl.reset_lvl <= 1'b0;
  endtask : t_reset

  task automatic t_test();
    logic [23:0] q;
    q = {3{8'hA5}};
    @(posedge ref_clk);
    ctrl.reset_lvl <= 1'b1;
    ctrl.skip8 <= 1'b1;
    @(posedge ref_clk);
    ctrl.set_lvl <= 1'b1;
    cyc(2);
    @(negedge ref_clk);
    chk("test_active", 24'h1, {23'h0, test_active});
    pulses(165);
    chk("stage_q test", q, stage_q);
    @(posedge ref_clk);
    ctrl.set_lvl <= 1'b0;
    ctrl.reset_lvl <= 1'b0;
    cyc(2);
    @(negedge ref_clk);
    chk("test_active exit", 24'h0, {23'h0, test_active});
    chk("stage_q exit", q, stage_q);
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge ref_clk);
        ctrl.skip8 <= s[0];
        stage_sel <= c[3:0];
        cyc(3);
        @(negedge ref_clk);
        chk("decode_out sel", {23'h0, q[8+c]}, {23'h0, decode_out});
      end
    end
    pulses(1);
    chk("stage_q skip", 24'hA5A6A5, stage_q);
    @(posedge ref_clk);
    ctrl.skip8 <= 1'b0;
    pulses(1);
    chk("stage_q series", 24'hA5A6A6, stage_q);
  endtask : t_test

  task automatic t_mono();
    int hi;
    @(posedge ref_clk);
    ctrl.reset_lvl <= 1'b1;
    cyc(2);
    ctrl.reset_lvl <= 1'b0;
    ctrl.skip8 <= 1'b1;
    stage_sel <= 4'h0;
    mono_en <= 1'b1;
    mono_width <= 8'h03;
    run_count(1, 0, 20, hi);
    chk("pulse width", 24'h000003, 24'(hi));
    @(posedge ref_clk);
    mono_en <= 1'b0;
    cyc(3);
    @(negedge ref_clk);
    chk("decode_out direct", 24'h1, {23'h0, decode_out});
    run_count(20, 6, 16, hi);
    chk("square high cycles", 24'h000008, 24'(hi));
  endtask : t_mono

  initial begin
    rst = 1'b1;
    ctrl = '0;
    stage_sel = 4'h0;
    mono_en = 1'b0;
    mono_width = 8'h00;
    go = 1'b0;
    n_edges = 16'h0000;
    slow = 1'b0;
    errors = 0;
    compares = 0;
    cyc(4);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("stage_q after rst", 24'h0, stage_q);
    chk("osc_drive_b after rst", 24'h1, {23'h0, osc_drive_b});
    t_count();
    t_set();
    t_reset();
    t_test();
    t_mono();
    give_verdict();
  end
endmodule : programmable_stage_timer_tb

/* verification/pst_clk_src.sv */
/*
  far-side model of the stage timer bench: external logic that sends a
  counted burst of falling edges on the count clock line, fast or slow.
  assumes one ref_clk domain; the line idles high between bursts.
*/
`timescale 1ns/1ps

module pst_clk_src (
  // clock
  input wire logic ref_clk,
  // burst request
  input wire logic go,
  input wire logic [15:0] n_edges,
  input wire logic slow,
  // clock line and status
  output logic clk_out,
  output logic busy
);
  logic [15:0] left_ff = 16'h0000;
  logic [1:0] wait_ff = 2'h0;
  logic line_ff = 1'b1;

  assign clk_out = line_ff;
  assign busy = (left_ff != 16'h0000);

  // line stands high outside a burst, so no stray edge leaks out
  always_ff @(posedge ref_clk) begin
    if (go && !busy) begin
      left_ff <= n_edges;
      wait_ff <= 2'h0;
    end else if (busy) begin
      if (wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end else begin
        line_ff <= ~line_ff;
        wait_ff <= slow ? 2'h2 : 2'h0;
        if (!line_ff) begin
          left_ff <= left_ff - 16'h0001;
        end
      end
    end
  end
endmodule : pst_clk_src
